//--- rtl/dtc_top.sv
`include "dtc_map.svh"
module dtc_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // special-function-register port
  input wire dtc_pkg::dtc_sfr_s sfr,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // interrupt vector acknowledges
  input wire logic vector_ack_zero,
  input wire logic vector_ack_one,
  // pins
  input wire logic event_input_zero,
  input wire logic event_input_one,
  input wire logic gate_pin_zero,
  input wire logic gate_pin_one,
  // flags
  output logic overflow_flag_zero,
  output logic overflow_flag_one
);
  localparam int unsigned MachineNs = `DTC_MACHINE_CLKS * `DTC_MCLK_NS;
  localparam int unsigned MachineClks = MachineNs / `DTC_MCLK_NS;

  logic [7:0] timer_mode;
  logic [7:0] timer_control;
  logic [`DTC_PHASE_W-1:0] phase;
  logic [1:0] ev_sync0;
  logic [1:0] ev_sync1;
  logic [1:0] gt_sync0;
  logic [1:0] gt_sync1;
  logic ev_prev0;
  logic ev_prev1;
  logic fall_pend0;
  logic fall_pend1;
  logic [7:0] low0;
  logic [7:0] high0;
  logic [7:0] low1;
  logic [7:0] high1;
  logic low_ovf0;
  logic high_ovf0;
  logic low_ovf1;
  logic high_ovf1;
  logic [7:0] next_control;

  wire dtc_pkg::dtc_cfg_s cfg0 = timer_mode[3:0];
  wire dtc_pkg::dtc_cfg_s cfg1 = timer_mode[7:4];
  wire run_zero = timer_control[`DTC_BIT_RUN_ZERO];
  wire run_one = timer_control[`DTC_BIT_RUN_ONE];
  wire split_mode = cfg0.mode == dtc_pkg::DTC_MODE_SPLIT;
  wire mc_end = phase == `DTC_PHASE_W'(MachineClks - 1);
  wire sample_now = phase == `DTC_PHASE_SAMPLE;
  wire load_now = phase == `DTC_PHASE_LOAD;

  // decode
  wire wr_mode = sfr.wr && sfr.addr == `DTC_ADDR_MODE;
  wire wr_ctrl = sfr.wr && sfr.addr == `DTC_ADDR_CONTROL;
  wire bit_ctrl = (sfr.bit_set || sfr.bit_clr) && sfr.addr == `DTC_ADDR_CONTROL;
  wire ld_low0 = sfr.wr && sfr.addr == `DTC_ADDR_LOW_ZERO;
  wire ld_low1 = sfr.wr && sfr.addr == `DTC_ADDR_LOW_ONE;
  wire ld_high0 = sfr.wr && sfr.addr == `DTC_ADDR_HIGH_ZERO;
  wire ld_high1 = sfr.wr && sfr.addr == `DTC_ADDR_HIGH_ONE;

  // enables: gate pin only matters when gate bit set
  wire en0 = run_zero && (!cfg0.gate || gt_sync0[1]);
  wire en1 = run_one && (!cfg1.gate || gt_sync1[1]);
  // counter increments land at S3P1 after fall seen at S5P2
  wire tick0 = cfg0.source ? (fall_pend0 && load_now) : mc_end;
  wire tick1 = cfg1.source ? (fall_pend1 && load_now) : mc_end;
  wire step_low0 = en0 && tick0;
  // timer one keeps running while timer zero is split but loses its flag to high0; its own split mode stops it
  wire step_low1 = en1 && tick1;
  wire stop1 = cfg1.mode == dtc_pkg::DTC_MODE_SPLIT;
  wire step_high0 = split_mode && run_one && mc_end;
  wire set_ovf0 = low_ovf0;
  wire set_ovf1 = split_mode ? high_ovf0 : low_ovf1;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= '0;
    end else if (ce) begin
      phase <= mc_end ? '0 : phase + `DTC_PHASE_W'(1);
    end
  end

  // pins come from outside: two flops before use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ev_sync0 <= 2'h0;
      ev_sync1 <= 2'h0;
      gt_sync0 <= 2'h0;
      gt_sync1 <= 2'h0;
    end else if (ce) begin
      ev_sync0 <= {ev_sync0[0], event_input_zero};
      ev_sync1 <= {ev_sync1[0], event_input_one};
      gt_sync0 <= {gt_sync0[0], gate_pin_zero};
      gt_sync1 <= {gt_sync1[0], gate_pin_one};
    end
  end

  // one sample per machine cycle, so two cycles per edge bounds the rate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ev_prev0 <= 1'b0;
      ev_prev1 <= 1'b0;
      fall_pend0 <= 1'b0;
      fall_pend1 <= 1'b0;
    end else if (ce) begin
      if (sample_now) begin
        ev_prev0 <= ev_sync0[1];
        ev_prev1 <= ev_sync1[1];
        fall_pend0 <= ev_prev0 && !ev_sync0[1];
        fall_pend1 <= ev_prev1 && !ev_sync1[1];
      end else if (load_now) begin
        fall_pend0 <= 1'b0;
        fall_pend1 <= 1'b0;
      end
    end
  end

  // control register: byte write or bit op; hardware set beats vector clear
  always_comb begin
    next_control = timer_control;
    if (wr_ctrl) begin
      next_control = sfr.wdata;
    end
    if (bit_ctrl) begin
      next_control[sfr.bit_sel] = sfr.bit_set;
    end
    if (vector_ack_zero) begin
      next_control[`DTC_BIT_OVF_ZERO] = 1'b0;
    end
    if (vector_ack_one) begin
      next_control[`DTC_BIT_OVF_ONE] = 1'b0;
    end
    if (set_ovf0) begin
      next_control[`DTC_BIT_OVF_ZERO] = 1'b1;
    end
    if (set_ovf1) begin
      next_control[`DTC_BIT_OVF_ONE] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control <= `DTC_CONTROL_RST;
      timer_mode <= `DTC_MODE_RST;
    end else if (ce) begin
      timer_control <= next_control;
      if (wr_mode) begin
        timer_mode <= sfr.wdata;
      end
    end
  end

  dtc_unit u_zero (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .cfg(cfg0),
    .low_step(step_low0),
    .high_step(step_high0),
    .stop_all(1'b0),
    .load_low(ld_low0),
    .load_high(ld_high0),
    .wdata(sfr.wdata),
    .count_low_byte(low0),
    .count_high_byte(high0),
    .low_ovf(low_ovf0),
    .high_ovf(high_ovf0)
  );

  dtc_unit u_one (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .cfg(cfg1),
    .low_step(step_low1),
    .high_step(1'b0),
    .stop_all(stop1),
    .load_low(ld_low1),
    .load_high(ld_high1),
    .wdata(sfr.wdata),
    .count_low_byte(low1),
    .count_high_byte(high1),
    .low_ovf(low_ovf1),
    .high_ovf()
  );

  // read mux; low nibble of control stored but unused by timers
  wire [7:0] rd_sel = sfr.addr == `DTC_ADDR_CONTROL ? timer_control :
                      sfr.addr == `DTC_ADDR_MODE ? timer_mode :
                      sfr.addr == `DTC_ADDR_LOW_ZERO ? low0 :
                      sfr.addr == `DTC_ADDR_LOW_ONE ? low1 :
                      sfr.addr == `DTC_ADDR_HIGH_ZERO ? high0 :
                      sfr.addr == `DTC_ADDR_HIGH_ONE ? high1 : 8'h00;
  assign sfr_hit = sfr.addr >= `DTC_ADDR_CONTROL && sfr.addr <= `DTC_ADDR_HIGH_ONE;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (ce && sfr.rd) begin
      sfr_rdata <= rd_sel;
    end
  end

  assign overflow_flag_zero = timer_control[`DTC_BIT_OVF_ZERO];
  assign overflow_flag_one = timer_control[`DTC_BIT_OVF_ONE];

  // assertions
  a_mode_reset_val: assert property (@(posedge mclk) $rose(rst_n) |-> timer_mode == 8'h00)
    else $error("mode register not zero after reset");
  a_timer_one_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && stop1 && !ld_low1 && !ld_high1) |=> $stable({low1, high1}))
    else $error("timer one moved in mode 11");
  a_run_off_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && !run_zero && !ld_low0 && !ld_high0 && !split_mode) |=> $stable({low0, high0}))
    else $error("timer zero moved while stopped");
  a_gate_blocks: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg0.gate && !gt_sync0[1]) |-> !step_low0)
    else $error("gated timer zero stepped with gate low");
  a_timer_cadence: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && step_low0 && !cfg0.source) |-> phase == 4'hB)
    else $error("timer step off machine cycle end");
  a_count_slot: assert property (@(posedge mclk) disable iff (!rst_n)
    (step_low0 && cfg0.source) |-> phase == `DTC_PHASE_LOAD && fall_pend0)
    else $error("counter step outside load slot");
  a_flag_set: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && set_ovf0) |=> overflow_flag_zero)
    else $error("overflow flag zero not set");
  a_reload_val: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && step_low0 && cfg0.mode == dtc_pkg::DTC_MODE_RELOAD && low0 == 8'hFF && !ld_low0
     && !ld_high0) |=> low0 == $past(high0))
    else $error("reload value wrong");
  a_sixteen_carry: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && step_low0 && cfg0.mode == dtc_pkg::DTC_MODE_SIXTEEN && low0 == 8'hFF && !ld_high0)
    |=> high0 == $past(high0) + 8'h01)
    else $error("sixteen-bit carry lost");

  // event path in steps: fall seen at the sample slot, pending until the load slot
  sequence s_fall_seen0;
    ce && sample_now && ev_prev0 && !ev_sync0[1];
  endsequence

  sequence s_pend_window0;
    fall_pend0 [*7] ##1 !fall_pend0;
  endsequence

  // a dropped clock enable stretches the window, so the check stands down then
  a_fall_pends: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    s_fall_seen0 |=> s_pend_window0)
    else $error("fall not held until load slot");

  a_fall_counts: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && cfg0.source && en0 && fall_pend0 && load_now) |-> step_low0)
    else $error("pending fall not counted at load slot");

  a_pend_origin: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && $rose(fall_pend0)) |-> $past(sample_now))
    else $error("fall pended outside sample slot");

  a_phase_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && mc_end) |=> phase == '0)
    else $error("machine cycle longer than twelve clocks");

  a_gate_one: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg1.gate && !gt_sync1[1]) |-> !step_low1)
    else $error("gated timer one stepped with gate low");

  a_source_one: assert property (@(posedge mclk) disable iff (!rst_n)
    (step_low1 && cfg1.source) |-> load_now && fall_pend1)
    else $error("timer one counter step without event");

  a_thirteen_carry: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && step_low0 && cfg0.mode == dtc_pkg::DTC_MODE_THIRTEEN && low0[4:0] == 5'h1F
     && !ld_high0) |=> high0 == $past(high0) + 8'h01)
    else $error("prescaler carry lost");

  a_split_high: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && split_mode && run_one && mc_end && !ld_high0) |=> high0 == $past(high0) + 8'h01)
    else $error("split high byte did not count");

  a_split_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && split_mode && high_ovf0) |=> overflow_flag_one)
    else $error("split high overflow did not set flag one");

  a_mode_bytes: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && !wr_mode) |=> $stable(timer_mode))
    else $error("mode register changed without byte write");

  a_ctrl_bitop: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && bit_ctrl && !set_ovf0 && !set_ovf1 && !vector_ack_zero && !vector_ack_one)
    |=> timer_control[$past(sfr.bit_sel)] == $past(sfr.bit_set))
    else $error("control bit operation lost");

  a_ack_clears: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && vector_ack_zero && !set_ovf0) |=> !overflow_flag_zero)
    else $error("vector acknowledge left flag zero set");

  a_run_no_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && bit_ctrl && sfr.bit_set && sfr.bit_sel == 3'h4 && !run_zero && !split_mode)
    |=> low0 == $past(low0) && high0 == $past(high0))
    else $error("setting run bit disturbed the count");

  a_rdata_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && !sfr.rd) |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
endmodule

//--- rtl/dtc_map.svh
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH
// special-function-register addresses
`define DTC_ADDR_CONTROL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_LOW_ZERO 8'h8A
`define DTC_ADDR_LOW_ONE 8'h8B
`define DTC_ADDR_HIGH_ZERO 8'h8C
`define DTC_ADDR_HIGH_ONE 8'h8D
// reset values
`define DTC_CONTROL_RST 8'h00
`define DTC_MODE_RST 8'h00
// control bit positions
`define DTC_BIT_OVF_ONE 7
`define DTC_BIT_RUN_ONE 6
`define DTC_BIT_OVF_ZERO 5
`define DTC_BIT_RUN_ZERO 4
// mode field positions within one timer nibble
`define DTC_BIT_GATE 3
`define DTC_BIT_SOURCE 2
// timing
`define DTC_MCLK_NS 10
`define DTC_MACHINE_CLKS 12
`define DTC_PHASE_W 4
`define DTC_PHASE_SAMPLE 4'h9
`define DTC_PHASE_LOAD 4'h4
`define DTC_PRESCALE_BITS 5
`endif

//--- rtl/dtc_pkg.sv
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_MODE_THIRTEEN,
    DTC_MODE_SIXTEEN,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_e;

  typedef struct packed {
    logic gate;
    logic source;
    dtc_mode_e mode;
  } dtc_cfg_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_set;
    logic bit_clr;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } dtc_sfr_s;
endpackage

//--- rtl/dtc_unit.sv
`include "dtc_map.svh"
// one timer/counter: count-byte pair plus mode-dependent step logic
module dtc_unit (
  // clock
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire dtc_pkg::dtc_cfg_s cfg,
  input wire logic low_step,
  input wire logic high_step,
  input wire logic stop_all,
  // software loads
  input wire logic load_low,
  input wire logic load_high,
  input wire logic [7:0] wdata,
  // state
  output logic [7:0] count_low_byte,
  output logic [7:0] count_high_byte,
  output logic low_ovf,
  output logic high_ovf
);
  logic [7:0] next_low;
  logic [7:0] next_high;
  logic lo5_wrap;
  logic lo8_wrap;
  logic hi_wrap;

  assign lo5_wrap = &count_low_byte[`DTC_PRESCALE_BITS-1:0];
  assign lo8_wrap = &count_low_byte;
  assign hi_wrap = &count_high_byte;

  always_comb begin
    next_low = count_low_byte;
    next_high = count_high_byte;
    low_ovf = 1'b0;
    high_ovf = 1'b0;
    if (low_step && !stop_all) begin
      case (cfg.mode)
        dtc_pkg::DTC_MODE_THIRTEEN: begin
          // upper three low bits ride along; they mean nothing here
          next_low = count_low_byte + 8'h01;
          if (lo5_wrap) begin
            next_low = {count_low_byte[7:5] + 3'h1, 5'h00};
            next_high = count_high_byte + 8'h01;
            low_ovf = hi_wrap;
          end
        end
        dtc_pkg::DTC_MODE_SIXTEEN: begin
          next_low = count_low_byte + 8'h01;
          if (lo8_wrap) begin
            next_high = count_high_byte + 8'h01;
            low_ovf = hi_wrap;
          end
        end
        dtc_pkg::DTC_MODE_RELOAD: begin
          next_low = lo8_wrap ? count_high_byte : count_low_byte + 8'h01;
          low_ovf = lo8_wrap;
        end
        dtc_pkg::DTC_MODE_SPLIT: begin
          next_low = count_low_byte + 8'h01;
          low_ovf = lo8_wrap;
        end
        default: next_low = count_low_byte;
      endcase
    end
    if (high_step) begin
      next_high = count_high_byte + 8'h01;
      high_ovf = hi_wrap;
    end
    if (load_low) begin
      next_low = wdata;
    end
    if (load_high) begin
      next_high = wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_low_byte <= 8'h00;
      count_high_byte <= 8'h00;
    end else if (ce) begin
      count_low_byte <= next_low;
      count_high_byte <= next_high;
    end
  end
endmodule

//--- testbench/dtc_pin_model.sv
// external pulse source on the two count pins, idle high between bursts
module dtc_pin_model (
  // clock
  input wire logic mclk,
  // count pins
  output logic event_input_zero,
  output logic event_input_one
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    event_input_zero = 1'b1;
    event_input_one = 1'b1;
  end

  // each level held two machine cycles so no edge can slip between samples
  task automatic pulses(input bit which, input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
      if (which) event_input_one = 1'b0;
      else event_input_zero = 1'b0;
      repeat (24) @(posedge mclk);
      #1;
      event_input_one = 1'b1;
      event_input_zero = 1'b1;
      repeat (24) @(posedge mclk);
    end
  endtask
endmodule

//--- testbench/tb_top.sv
`include "dtc_map.svh"
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] OP_WR = 4'h8;
  localparam logic [3:0] OP_RD = 4'h4;
  localparam logic [3:0] OP_SET = 4'h2;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [7:0] CTL = `DTC_ADDR_CONTROL;
  localparam logic [7:0] MOD = `DTC_ADDR_MODE;
  localparam logic [7:0] LO0 = `DTC_ADDR_LOW_ZERO;
  localparam logic [7:0] LO1 = `DTC_ADDR_LOW_ONE;
  localparam logic [7:0] HI0 = `DTC_ADDR_HIGH_ZERO;
  localparam logic [7:0] HI1 = `DTC_ADDR_HIGH_ONE;

  logic mclk;
  logic rst_n;
  logic ce;
  dtc_pkg::dtc_sfr_s sfr;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  logic vector_ack_zero;
  logic vector_ack_one;
  logic event_input_zero;
  logic event_input_one;
  logic gate_pin_zero;
  logic gate_pin_one;
  logic overflow_flag_zero;
  logic overflow_flag_one;
  logic [7:0] q;
  int fails;
  int num_checks;

  dtc_top dtc_top_i (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .vector_ack_zero(vector_ack_zero),
    .vector_ack_one(vector_ack_one), .event_input_zero(event_input_zero),
    .event_input_one(event_input_one), .gate_pin_zero(gate_pin_zero),
    .gate_pin_one(gate_pin_one), .overflow_flag_zero(overflow_flag_zero),
    .overflow_flag_one(overflow_flag_one)
  );

  dtc_pin_model dtc_pin_model_i (
    .mclk(mclk), .event_input_zero(event_input_zero), .event_input_one(event_input_one)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // one access, then an idle cycle so the strobe never changes twice at once
  task automatic acc(input logic [3:0] op, input logic [7:0] a, input logic [2:0] b,
                     input logic [7:0] d);
    @(posedge mclk);
    #1;
    sfr = {op, a, b, d};
    @(posedge mclk);
    #1;
    q = sfr_rdata;
    sfr = '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(OP_WR, a, 3'h0, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    acc(OP_RD, a, 3'h0, 8'h00);
    `CHK(q, exp)
  endtask

  // run bit high for exactly 120 edges: ten machine-cycle steps at any phase
  task automatic window(input logic [2:0] b);
    acc(OP_SET, CTL, b, 8'h00);
    repeat (118) @(posedge mclk);
    acc(OP_CLR, CTL, b, 8'h00);
  endtask

  task automatic ack(input bit which);
    @(posedge mclk);
    #1;
    if (which) vector_ack_one = 1'b1;
    else vector_ack_zero = 1'b1;
    @(posedge mclk);
    #1;
    vector_ack_one = 1'b0;
    vector_ack_zero = 1'b0;
  endtask

  task automatic finish_test();
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    finish_test();
  end

  initial begin
    fails = 0;
    num_checks = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    sfr = '0;
    vector_ack_zero = 1'b0;
    vector_ack_one = 1'b0;
    gate_pin_zero = 1'b1;
    gate_pin_one = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    rd_chk(CTL, 8'h00);
    #1;
    sfr.addr = HI1;
    #2;
    `CHK(sfr_hit, 1'b1)
    sfr.addr = 8'h8E;
    #2;
    `CHK(sfr_hit, 1'b0)
    sfr = '0;
    rd_chk(MOD, 8'h00);
    wr(CTL, 8'h0F);
    repeat (30) @(posedge mclk);
    rd_chk(CTL, 8'h0F);
    rd_chk(LO0, 8'h00);
    wr(CTL, 8'h00);
    acc(OP_SET, MOD, 3'h0, 8'h00);
    rd_chk(MOD, 8'h00);
    wr(MOD, 8'h01);
    rd_chk(MOD, 8'h01);
    wr(LO0, 8'hF8);
    wr(HI0, 8'hFF);
    rd_chk(LO0, 8'hF8);
    window(3'h4);
    rd_chk(LO0, 8'h02);
    rd_chk(HI0, 8'h00);
    `CHK(overflow_flag_zero, 1'b1)
    rd_chk(CTL, 8'h20);
    ack(1'b0);
    `CHK(overflow_flag_zero, 1'b0)
    // gated: pin low must freeze the count despite the run bit
    wr(MOD, 8'h09);
    gate_pin_zero = 1'b0;
    wr(LO0, 8'h00);
    window(3'h4);
    rd_chk(LO0, 8'h00);
    gate_pin_zero = 1'b1;
    window(3'h4);
    rd_chk(LO0, 8'h0A);
    // counter source: 277 clocks elapse with run set, so a timer would show 23 or 24
    wr(MOD, 8'h05);
    wr(LO0, 8'h00);
    acc(OP_SET, CTL, 3'h4, 8'h00);
    dtc_pin_model_i.pulses(1'b0, 5);
    repeat (30) @(posedge mclk);
    acc(OP_CLR, CTL, 3'h4, 8'h00);
    rd_chk(LO0, 8'h05);
    wr(MOD, 8'h00);
    wr(LO0, 8'h1E);
    wr(HI0, 8'h00);
    window(3'h4);
    acc(OP_RD, LO0, 3'h0, 8'h00);
    `CHK(q[4:0], 5'h08)
    rd_chk(HI0, 8'h01);
    wr(MOD, 8'h20);
    wr(LO1, 8'hFE);
    wr(HI1, 8'hF0);
    window(3'h6);
    rd_chk(LO1, 8'hF8);
    rd_chk(HI1, 8'hF0);
    `CHK(overflow_flag_one, 1'b1)
    ack(1'b1);
    `CHK(overflow_flag_one, 1'b0)
    wr(MOD, 8'h33);
    wr(LO0, 8'h00);
    wr(HI0, 8'h00);
    wr(CTL, 8'h50);
    repeat (118) @(posedge mclk);
    wr(CTL, 8'h00);
    rd_chk(LO0, 8'h0A);
    rd_chk(HI0, 8'h0A);
    rd_chk(LO1, 8'hF8);
    rd_chk(HI1, 8'hF0);
    repeat (24) @(posedge mclk);
    rd_chk(LO0, 8'h0A);
    finish_test();
  end
endmodule
